// ---- testbench/prli_led_ctrl_asserts.sv ----
// Purpose: port-level checks of the indicator controller
// Assumes: shortened cycle counts handed down by the bind
// Notes: only channel one is tracked by the qualifier shadow, to stay small
module prli_led_ctrl_asserts
    import prli_pkg::*;
#(
    parameter int unsigned LAMP_CYCLES = 40,
    parameter int unsigned PROTECT_CYCLES = 10,
    parameter int unsigned QUAL_CYCLES = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ARC_CHANNELS-1:0] arc_active,
    input wire logic [TRIP_LINES-1:0] trip_event,
    input wire logic [ARC_CHANNELS-1:0] arc_fault,
    input wire logic [BIN_IN_LINES-1:0] binary_in_fault,
    input wire logic config_mismatch,
    input wire logic system_failure,
    input wire logic clear_button,
    input wire logic [LED_COUNT-1:0] led_q,
    input wire logic protect_en_q,
    input wire logic relay_reset_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    int unsigned cyc_q;
    logic [7:0] run_q;
    logic seen_q;
    logic healthy;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) cyc_q <= 0;
        else if (cyc_q < 32'hFFFF) cyc_q <= cyc_q + 1;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 8'h00;
        end else if (!arc_active[0]) begin
            run_q <= 8'h00;
        end else if (run_q != 8'hFF) begin
            run_q <= run_q + 8'h01;
        end
    end
    // remembers a run long enough to qualify, so the lit lamp can be tied to it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seen_q <= 1'b0;
        end else if (relay_reset_q) begin
            seen_q <= 1'b0;
        end else if (arc_active[0] && run_q >= QUAL_CYCLES) begin
            seen_q <= 1'b1;
        end
    end
    assign healthy = !system_failure && !config_mismatch && arc_fault == '0 && binary_in_fault == '0
        && cyc_q > LAMP_CYCLES + 3;
    chk_lamp_all_on: assert property (cyc_q >= 3 && cyc_q <= LAMP_CYCLES - 2 |-> &led_q)
        else $error("lamp test not all lit");
    chk_power_lit: assert property (cyc_q > 2 |-> led_q[0])
        else $error("power lamp dark");
    chk_protect_early: assert property (cyc_q < PROTECT_CYCLES - 1 |-> !protect_en_q)
        else $error("protection began too early");
    chk_protect_late: assert property (cyc_q > PROTECT_CYCLES + 1 |-> protect_en_q)
        else $error("protection not begun in time");
    chk_short_arc: assert property (cyc_q > LAMP_CYCLES + 3 && $rose(led_q[12])
        && !$past(config_mismatch) && !$past(arc_fault[0]) |-> seen_q)
        else $error("arc lamp lit without qualified run");
    chk_trip_lamp: assert property (trip_event[0] && protect_en_q |-> ##2 led_q[2])
        else $error("trip lamp not lit");
    chk_fail_steady: assert property (system_failure [*3] |-> led_q[1])
        else $error("error lamp not steady on failure");
    chk_healthy_dark: assert property (healthy [*3] |-> !led_q[1])
        else $error("error lamp lit while healthy");
    chk_relay_pulse: assert property (relay_reset_q |=> !relay_reset_q)
        else $error("relay reset longer than one cycle");
    chk_clear_cause: assert property ($rose(relay_reset_q) |-> $past(clear_button) || $past(clear_button, 2))
        else $error("relay reset without press");
endmodule

bind prli_led_ctrl prli_led_ctrl_asserts #(.LAMP_CYCLES(LAMP_CYCLES), .PROTECT_CYCLES(PROTECT_CYCLES),
    .QUAL_CYCLES(QUAL_CYCLES)) i_chk (.clk(clk), .reset(reset), .arc_active(arc_active), .trip_event(trip_event),
    .arc_fault(arc_fault), .binary_in_fault(binary_in_fault), .config_mismatch(config_mismatch),
    .system_failure(system_failure), .clear_button(clear_button), .led_q(led_q), .protect_en_q(protect_en_q),
    .relay_reset_q(relay_reset_q));

// ---- testbench/prli_led_ctrl_tb.sv ----
// Purpose: self-checking bench of the indicator controller
// Assumes: shortened counts: lamp 40, protect 10, qualify 5, flash 4
// Notes: inputs change on the falling edge only
module prli_led_ctrl_tb
    import prli_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ARC_CHANNELS-1:0] arc = '0, arc_flt = '0;
    logic [BIN_IN_LINES-1:0] bin_in = '0, bin_flt = '0, brk = '0;
    logic [BIN_OUT_LINES-1:0] bin_out = '0;
    logic [TRIP_LINES-1:0] trip = '0;
    logic mism = 1'b0, sysf = 1'b0, btn = 1'b0;
    logic [NV_BITS-1:0] nv_rd, nv_wd;
    logic [LED_COUNT-1:0] led;
    logic prot, rrst, nv_wr;
    int mismatches = 0, checks_done = 0, cycles = 0;
    always #10 clk = ~clk;
    prli_led_ctrl #(.LAMP_CYCLES(40), .PROTECT_CYCLES(10), .QUAL_CYCLES(5), .FLASH_CYCLES(4)) i_dut (
        .clk(clk), .reset(reset), .arc_active(arc), .binary_in_active(bin_in), .binary_out_active(bin_out),
        .trip_event(trip), .arc_fault(arc_flt), .binary_in_fault(bin_flt), .config_mismatch(mism),
        .system_failure(sysf), .breaker_connected(brk), .clear_button(btn), .nv_rd_data(nv_rd), .led_q(led),
        .protect_en_q(prot), .relay_reset_q(rrst), .nv_wr_q(nv_wr), .nv_wr_data_q(nv_wd));
    prli_nv_model i_nv (.clk(clk), .nv_wr_q(nv_wr), .nv_wr_data_q(nv_wd), .nv_rd_data(nv_rd));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // the whole run needs about 220 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic power_up();
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        cyc(5);
        check("protect early", prot, 16'h0000);
        cyc(15);
        check("lamp test", led, 16'hFFFF);
        check("protect", prot, 16'h0001);
        cyc(30);
    endtask
    task automatic t_arc();
        arc = 4'h1;
        cyc(5);
        arc = 4'h0;
        cyc(1);
        arc = 4'h1;
        cyc(5);
        arc = 4'h0;
        cyc(4);
        check("short pulses", led, 16'h0001);
        arc = 4'h1;
        cyc(8);
        arc = 4'h0;
        cyc(4);
        check("arc latched", led, 16'h1001);
    endtask
    task automatic t_lines();
        bin_in = 6'h04;
        bin_out = 2'h1;
        cyc(8);
        bin_in = 6'h00;
        bin_out = 2'h0;
        trip = 3'h3;
        cyc(1);
        trip = 3'h0;
        cyc(4);
        check("lines and trips", led, 16'h144D);
        brk = 6'h01;
        bin_in = 6'h01;
        cyc(3);
        check("breaker live", led, 16'h145D);
        bin_in = 6'h00;
        cyc(3);
        check("breaker open", led, 16'h144D);
        brk = 6'h00;
    endtask
    task automatic t_clear();
        logic [15:0] n;
        logic [15:0] w;
        n = 16'h0000;
        w = 16'h0000;
        btn = 1'b1;
        for (int i = 0; i < 6; i++) begin
            cyc(1);
            n = n + 16'(rrst);
            w = w + 16'(nv_wr);
            if (i == 2) btn = 1'b0;
        end
        check("relay reset count", n, 16'h0001);
        check("cleared", led, 16'h0001);
        check("store writes", w, 16'h0001);
        check("store image", nv_wd, 16'h0000);
        trip = 3'h4;
        cyc(1);
        trip = 3'h0;
        cyc(3);
        check("shared trip lamps", led, 16'h000D);
        btn = 1'b1;
        cyc(2);
        btn = 1'b0;
        cyc(2);
        check("cleared again", led, 16'h0001);
    endtask
    task automatic t_fault();
        logic on, off, step;
        for (int k = 0; k < 2; k++) begin
            on = 1'b0;
            off = 1'b0;
            step = 1'b1;
            arc_flt = (k == 0) ? 4'h3 : 4'h0;
            mism = (k == 1);
            cyc(2);
            repeat (16) begin
                cyc(1);
                on |= led[13] & led[1];
                off |= !led[13] & !led[1];
                step &= (led[12] === led[13]) && (led[13] === led[1]);
            end
            check("flash", {on, off, step}, 16'h0007);
        end
        mism = 1'b0;
        sysf = 1'b1;
        cyc(3);
        on = 1'b1;
        repeat (8) begin
            cyc(1);
            on &= led[1];
        end
        check("error steady", on, 16'h0001);
        sysf = 1'b0;
        cyc(3);
        check("healthy", led, 16'h0001);
    endtask
    initial begin
        power_up();
        check("idle display", led, 16'h0001);
        t_arc();
        t_lines();
        power_up();
        check("restored", led, 16'h144D);
        t_clear();
        t_fault();
        close_out();
    end
endmodule

// ---- testbench/prli_nv_model.sv ----
// Purpose: non-volatile store standing beside the controller
// Assumes: writes taken on the clock edge where the strobe is high
// Notes: no reset input, so the image survives a power cycle
module prli_nv_model
    import prli_pkg::*;
(
    input wire logic clk,
    input wire logic nv_wr_q,
    input wire logic [NV_BITS-1:0] nv_wr_data_q,
    output logic [NV_BITS-1:0] nv_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NV_BITS-1:0] image_q = '0;
    always @(posedge clk) begin
        if (nv_wr_q) begin
            image_q <= nv_wr_data_q;
        end
    end
    assign nv_rd_data = image_q;
endmodule

// ---- verilog/prli_led_ctrl.sv ----
// Purpose: front-panel indicator controller of an arc protection relay
// Assumes: 50 MHz clock, inputs synchronous, external non-volatile store
// Notes: nv store holds latched indications; it is read once after reset
//
// Contract
// - sixteen separately driven indicators: power, error, arc, binary lines, trips.
// - on power-up all indicators lit two seconds, then only power stays on; restored latched indications stay lit too.
// - protection mode starts 50 ms after power-up, alongside the lamp test.
// - normally power lit plus breaker status indicators of connected breakers.
// - arc channel indicator dark while its channel is inactive; a latched arc keeps it lit.
// - arc indicator sets only after activation longer than 1.5 ms.
// - arc indicator stays latched steadily until the push-button is pressed.
// - loose wire or mismatch flashes channel indicator and raises error.
// - binary line indicator lights and latches after more than 1.5 ms active.
// - trip lights the indicator of the trip output that operated; the third trip output lights both trip lamps.
// - activation and trip indications latch regardless of latching switch.
// - latched indications saved to non-volatile memory, restored at power return.
// - error off healthy, steady on failure, blinking on configuration mismatch.
// - push-button clears latched indications and latched output relays.
module prli_led_ctrl
    import prli_pkg::*;
#(
    parameter int unsigned LAMP_CYCLES = LAMP_TEST_CYC,
    parameter int unsigned PROTECT_CYCLES = PROTECT_CYC,
    parameter int unsigned QUAL_CYCLES = QUAL_CYC,
    parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ARC_CHANNELS-1:0] arc_active,
    input wire logic [BIN_IN_LINES-1:0] binary_in_active,
    input wire logic [BIN_OUT_LINES-1:0] binary_out_active,
    input wire logic [TRIP_LINES-1:0] trip_event,
    input wire logic [ARC_CHANNELS-1:0] arc_fault,
    input wire logic [BIN_IN_LINES-1:0] binary_in_fault,
    input wire logic config_mismatch,
    input wire logic system_failure,
    input wire logic [BIN_IN_LINES-1:0] breaker_connected,
    input wire logic clear_button,
    input wire logic [NV_BITS-1:0] nv_rd_data,
    output logic [LED_COUNT-1:0] led_q,
    output logic protect_en_q,
    output logic relay_reset_q,
    output logic nv_wr_q,
    output logic [NV_BITS-1:0] nv_wr_data_q
);
    localparam int unsigned LW = $clog2(LAMP_CYCLES + 1);
    localparam int unsigned PW = $clog2(PROTECT_CYCLES + 1);
    localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);

    initial begin
        if (LAMP_CYCLES == 0 || PROTECT_CYCLES == 0 || QUAL_CYCLES == 0 || FLASH_CYCLES == 0) begin
            $error("prli_led_ctrl: counts must be nonzero");
        end
        if (LED_COUNT != LED_ARC_BASE + ARC_CHANNELS) begin
            $error("prli_led_ctrl: indicator map does not fill 16 outputs");
        end
        if (LED_BIN_IN_BASE != LED_TRIP_BASE + TRIP_LAMPS || LED_BIN_OUT_BASE != LED_BIN_IN_BASE + BIN_IN_LINES
            || LED_ARC_BASE != LED_BIN_OUT_BASE + BIN_OUT_LINES) begin
            $error("prli_led_ctrl: indicator groups overlap or leave gaps");
        end
        if (TRIP_LINES != TRIP_LAMPS + 1) begin
            $error("prli_led_ctrl: trip lamp sharing needs one more trip output than lamps");
        end
    end

    prli_state_t state_q;
    logic [LW-1:0] lamp_cnt_q;
    logic [PW-1:0] prot_cnt_q;
    logic [FW-1:0] flash_cnt_q;
    logic flash_phase_q;
    logic btn_q;
    logic clear_pulse;
    logic [ARC_CHANNELS-1:0] arc_latch_q;
    logic [BIN_IN_LINES-1:0] bin_in_latch_q;
    logic [BIN_OUT_LINES-1:0] bin_out_latch_q;
    logic [TRIP_LINES-1:0] trip_latch_q;
    logic [NV_BITS-1:0] nv_image;
    logic [LED_COUNT-1:0] led_d;
    logic [1:0] err_mode;

    prli_qual_if #(.N(QUAL_LINES)) qif ();

    assign qif.raw = {binary_out_active, binary_in_active, arc_active};

    prli_qualifier #(.N(QUAL_LINES), .THRESH(QUAL_CYCLES)) u_qual (
        .clk(clk),
        .reset(reset),
        .q(qif)
    );

    // error mode: failure outranks mismatch
    function automatic logic [1:0] err_decode(input logic fail, input logic mism);
        if (fail) begin
            return ERR_FAILURE;
        end else if (mism) begin
            return ERR_MISMATCH;
        end
        return ERR_HEALTHY;
    endfunction

    // two lamps serve three trip outputs: the last output lights both lamps
    function automatic logic [TRIP_LAMPS-1:0] trip_lamps(input logic [TRIP_LINES-1:0] latched);
        logic [TRIP_LAMPS-1:0] lamps;
        lamps = '0;
        for (int i = 0; i < TRIP_LAMPS; i++) begin
            lamps[i] = latched[i] | latched[TRIP_LINES-1];
        end
        return lamps;
    endfunction

    // button edge: one clear per press, so a held button does not mask new events forever
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            btn_q <= 1'b0;
        end else begin
            btn_q <= clear_button;
        end
    end
    assign clear_pulse = clear_button && !btn_q && (state_q == PRLI_ST_RUN);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            relay_reset_q <= 1'b0;
        end else begin
            relay_reset_q <= clear_pulse;
        end
    end

    // power-up sequence: restore store, then lamp test
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= PRLI_ST_RESTORE;
            lamp_cnt_q <= '0;
        end else begin
            case (state_q)
                PRLI_ST_RESTORE: begin
                    state_q <= PRLI_ST_LAMP_TEST;
                end
                PRLI_ST_LAMP_TEST: begin
                    if (lamp_cnt_q == LW'(LAMP_CYCLES - 1)) begin
                        state_q <= PRLI_ST_RUN;
                    end
                    lamp_cnt_q <= lamp_cnt_q + LW'(1);
                end
                PRLI_ST_RUN: begin
                    state_q <= PRLI_ST_RUN;
                end
                default: begin
                    state_q <= PRLI_ST_RESTORE;
                end
            endcase
        end
    end

    // protection runs on its own counter, not gated by the lamp test
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prot_cnt_q <= '0;
            protect_en_q <= 1'b0;
        end else if (!protect_en_q) begin
            if (prot_cnt_q == PW'(PROTECT_CYCLES - 1)) begin
                protect_en_q <= 1'b1;
            end
            prot_cnt_q <= prot_cnt_q + PW'(1);
        end
    end

    // one shared blink timebase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flash_cnt_q <= '0;
            flash_phase_q <= 1'b0;
        end else if (flash_cnt_q == FW'(FLASH_CYCLES - 1)) begin
            flash_cnt_q <= '0;
            flash_phase_q <= !flash_phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + FW'(1);
        end
    end

    // latches: restored from store after reset, set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            arc_latch_q <= '0;
            bin_in_latch_q <= '0;
            bin_out_latch_q <= '0;
            trip_latch_q <= '0;
        end else if (state_q == PRLI_ST_RESTORE) begin
            {trip_latch_q, bin_out_latch_q, bin_in_latch_q, arc_latch_q} <= nv_rd_data;
        end else if (protect_en_q) begin
            arc_latch_q <= (clear_pulse ? '0 : arc_latch_q)
                | qif.hit[ARC_CHANNELS-1:0];
            bin_in_latch_q <= (clear_pulse ? '0 : bin_in_latch_q)
                | qif.hit[ARC_CHANNELS +: BIN_IN_LINES];
            bin_out_latch_q <= (clear_pulse ? '0 : bin_out_latch_q)
                | qif.hit[ARC_CHANNELS + BIN_IN_LINES +: BIN_OUT_LINES];
            trip_latch_q <= (clear_pulse ? '0 : trip_latch_q) | trip_event;
        end
    end

    // store write-through whenever the latched image changes
    assign nv_image = {trip_latch_q, bin_out_latch_q, bin_in_latch_q, arc_latch_q};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nv_wr_data_q <= '0;
            nv_wr_q <= 1'b0;
        end else begin
            // latches may already set during the lamp test, so writes run from then on
            nv_wr_q <= (state_q != PRLI_ST_RESTORE) && (nv_image != nv_wr_data_q);
            nv_wr_data_q <= nv_image;
        end
    end

    assign err_mode = err_decode(system_failure,
        config_mismatch || (|arc_fault) || (|binary_in_fault));

    always_comb begin
        led_d = '0;
        led_d[LED_POWER] = 1'b1;
        case (err_mode)
            ERR_FAILURE: led_d[LED_ERROR] = 1'b1;
            ERR_MISMATCH: led_d[LED_ERROR] = flash_phase_q;
            default: led_d[LED_ERROR] = 1'b0;
        endcase
        led_d[LED_TRIP_BASE +: TRIP_LAMPS] = trip_lamps(trip_latch_q);
        for (int i = 0; i < BIN_IN_LINES; i++) begin
            // breaker status shown live for connected breakers on top of the latch, latch alone otherwise
            if (binary_in_fault[i]) begin
                led_d[LED_BIN_IN_BASE + i] = flash_phase_q;
            end else begin
                led_d[LED_BIN_IN_BASE + i] = bin_in_latch_q[i]
                    | (breaker_connected[i] & binary_in_active[i]);
            end
        end
        for (int i = 0; i < BIN_OUT_LINES; i++) begin
            led_d[LED_BIN_OUT_BASE + i] = bin_out_latch_q[i];
        end
        for (int i = 0; i < ARC_CHANNELS; i++) begin
            if (arc_fault[i] || config_mismatch) begin
                led_d[LED_ARC_BASE + i] = flash_phase_q;
            end else begin
                led_d[LED_ARC_BASE + i] = arc_latch_q[i];
            end
        end
        if (state_q != PRLI_ST_RUN) begin
            led_d = '1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            led_q <= '0;
        end else begin
            led_q <= led_d;
        end
    end
endmodule

// ---- verilog/prli_pkg.sv ----
// Purpose: constants for the protection relay indicator controller
// Assumes: 50 MHz clock, 16 indicators
// Notes: times are kept in their own unit, cycle counts derived here
package prli_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LED_COUNT = 16;
    localparam int unsigned ARC_CHANNELS = 4;
    localparam int unsigned BIN_IN_LINES = 6;
    localparam int unsigned BIN_OUT_LINES = 2;
    localparam int unsigned TRIP_LINES = 3;
    localparam int unsigned LAMP_TEST_MS = 2000;
    localparam int unsigned PROTECT_MS = 50;
    localparam int unsigned QUAL_US = 1500;
    localparam int unsigned FLASH_MS = 250;
    localparam int unsigned LAMP_TEST_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
    localparam int unsigned PROTECT_CYC = PROTECT_MS * (CLK_HZ / 1000);
    localparam int unsigned QUAL_CYC = QUAL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
    // indicator positions in the 16-bit output vector
    localparam int unsigned LED_POWER = 0;
    localparam int unsigned LED_ERROR = 1;
    // three trip outputs share two lamps, so all sixteen lamps stay separate
    localparam int unsigned TRIP_LAMPS = 2;
    localparam int unsigned LED_TRIP_BASE = 2;
    localparam int unsigned LED_BIN_IN_BASE = 4;
    localparam int unsigned LED_BIN_OUT_BASE = 10;
    localparam int unsigned LED_ARC_BASE = 12;
    localparam int unsigned QUAL_LINES = ARC_CHANNELS + BIN_IN_LINES + BIN_OUT_LINES;
    localparam int unsigned NV_BITS = ARC_CHANNELS + BIN_IN_LINES + BIN_OUT_LINES + TRIP_LINES;
    localparam logic [1:0] ERR_HEALTHY = 2'h0;
    localparam logic [1:0] ERR_FAILURE = 2'h1;
    localparam logic [1:0] ERR_MISMATCH = 2'h2;
    typedef enum logic [1:0] {
        PRLI_ST_RESTORE = 2'h0,
        PRLI_ST_LAMP_TEST = 2'h1,
        PRLI_ST_RUN = 2'h2
    } prli_state_t;
endpackage

// ---- verilog/prli_qual_if.sv ----
// Purpose: qualifier hookup between controller and qualifier bank
// Assumes: one clock domain
// Notes: raw lines in, qualified levels out
interface prli_qual_if #(parameter int unsigned N = 12);
    logic [N-1:0] raw;
    logic [N-1:0] hit;
    modport ctrl (output raw, input hit);
    modport qual (input raw, output hit);
endinterface

// ---- verilog/prli_qualifier.sv ----
// Purpose: continuous-activation qualifier bank
// Assumes: inputs synchronous to clk
// Notes: hit is a level, high once a line has stayed active past the threshold
module prli_qualifier #(
    parameter int unsigned N = 12,
    parameter int unsigned THRESH = 75
) (
    input wire logic clk,
    input wire logic reset,
    prli_qual_if.qual q
);
    localparam int unsigned CW = $clog2(THRESH + 2);
    initial begin
        if (N == 0 || THRESH == 0) begin
            $error("prli_qualifier: bad parameters");
        end
    end
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_line
            logic [CW-1:0] cnt_q;
            logic hit_q;
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    cnt_q <= '0;
                end else if (!q.raw[i]) begin
                    cnt_q <= '0;
                end else if (cnt_q <= CW'(THRESH)) begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
            // longer than the threshold: one count past it
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    hit_q <= 1'b0;
                end else begin
                    hit_q <= q.raw[i] && (cnt_q >= CW'(THRESH));
                end
            end
            assign q.hit[i] = hit_q;
        end
    endgenerate
endmodule
